// file: rtl/irq_ctrl_pkg.sv
// Purpose: Shared constants and carriers of the prioritized interrupt controller
// Assumes: APB slave with 32-bit data, one clock pclk at 250 MHz
// Notes:   Vector slot n lives in pending bit n-1
package irq_ctrl_pkg;

    localparam int unsigned CLK_MHZ       = 250;
    localparam int unsigned NUM_SRC       = 12;
    localparam int unsigned PC_W          = 14;

    // Register byte addresses
    localparam logic [7:0] OFF_GLOBAL_EN  = 8'h20;
    localparam logic [7:0] OFF_EP_EN      = 8'h24;
    localparam logic [7:0] OFF_STATUS     = 8'h28;
    localparam logic [7:0] OFF_PENDING    = 8'h2C;

    // Global enable fields
    localparam int unsigned GE_BUS_RESET  = 0;
    localparam int unsigned GE_T128US     = 1;
    localparam int unsigned GE_T1024MS    = 2;
    localparam int unsigned GE_DAC        = 4;
    localparam int unsigned GE_GPIO       = 5;
    localparam int unsigned GE_I2C        = 6;
    localparam logic [7:0]  GE_WR_MASK    = 8'h77;
    localparam logic [7:0]  EP_WR_MASK    = 8'h1F;
    localparam logic [7:0]  EN_RESET      = 8'h00;

    // Processor status fields
    localparam int unsigned ST_IRQ_PEND   = 7;
    localparam int unsigned ST_BUS_RESET  = 5;
    localparam int unsigned ST_GIE_SENSE  = 2;

    // Pending bit index of each vector
    localparam int unsigned V_BUS_RESET   = 0;
    localparam int unsigned V_T128US      = 1;
    localparam int unsigned V_T1024MS     = 2;
    localparam int unsigned V_EP_FIRST    = 3;
    localparam int unsigned V_DAC         = 9;
    localparam int unsigned V_GPIO        = 10;
    localparam int unsigned V_I2C         = 11;

    localparam logic [PC_W-1:0] RESET_VECTOR = 14'h0000;
    localparam logic [PC_W-1:0] VECTOR_STEP  = 14'h0002;

    // Service timing
    localparam int unsigned CALL_CYCLES   = 10;
    localparam int unsigned JUMP_CYCLES   = 5;
    localparam logic [3:0]  CALL_LAST     = 4'(CALL_CYCLES - 1);

    // SE0 detection window, in ns: earliest 12 us, latest 16 us
    localparam int unsigned SE0_MIN_NS    = 12000;
    localparam int unsigned SE0_MAX_NS    = 16000;
    localparam int unsigned SE0_DET_CYC   = (SE0_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam logic [11:0] SE0_DET_CNT   = 12'(SE0_DET_CYC);

    typedef struct packed {
        logic       tick_128us;
        logic       tick_1024ms;
        logic [4:0] ep_event;
        logic       dac_event;
        logic       gpio_event;
        logic       i2c_event;
    } irq_src_t;

    typedef struct packed {
        logic boundary;
        logic disable_irq_instr;
        logic enable_irq_instr;
        logic return_from_irq_instr;
    } cpu_ctl_t;

    typedef struct packed {
        logic            call_active;
        logic [PC_W-1:0] vector;
    } service_t;

    typedef enum logic [1:0] {
        SVC_IDLE = 2'b01,
        SVC_CALL = 2'b10
    } svc_state_t;

endpackage : irq_ctrl_pkg

// file: rtl/prioritized_interrupt_controller.sv
// Purpose: Pending, masking, priority and call injection for the MCU interrupts
// Assumes: Source events and CPU strobes are one-cycle pulses synchronous to pclk
// Notes:   The CPU pushes PC, carry_flag, zero_flag during the injected call
//
// Behaviour
// [RULE_01] Global enable bit 2 gates the 1.024 ms timer interrupt.
// [RULE_02] Global enable bit 4 gates the DAC pin interrupt.
// [RULE_03] Global enable bit 5 gates the shared GPIO edge interrupt.
// [RULE_04] Global enable bit 6 gates the I2C interrupt; bits 3 and 7 reserved.
// [RULE_05] Endpoint enable bits 0..4 gate endpoints A0, A1, A2, B0, B1; 7..5 reserved.
// [RULE_06] Reset clears both enable registers, disabling every interrupt.
// [RULE_07] One pending flop per source, set by event, held until serviced or reset.
// [RULE_08] Pending flop requests only while enabled; disabled ones stay pending.
// [RULE_09] Highest enabled request is taken only at an instruction boundary.
// [RULE_10] Lowest vector number wins: bus reset first, I2C last.
// [RULE_11] First service step clears CPU global enable, seen in status bit 2.
// [RULE_12] Second step clears only the serviced pending flop.
// [RULE_13] Third step injects a call to the vector; PC and flags get pushed.
// [RULE_14] Return-from-interrupt restores PC and flags and sets global enable.
// [RULE_15] Disable and enable instructions touch only global enable; nesting allowed.
// [RULE_16] Any pending interrupt shows in status bit 7 while global enable clear.
// [RULE_17] Execution starts at 0x0000 after reset; vectors are two bytes apart.
// [RULE_18] Vectors: bus reset 0x0002 through I2C 0x0018, 0x0012 reserved.
// [RULE_19] Latency is remaining instruction cycles plus 10 call plus 5 jump.
// [RULE_20] Bus reset detected on SE0 after at least 12 us, at most 16 us.
// [RULE_21] Detection sets status bit 5; interrupt raised when SE0 ends.
// [RULE_22] Bus reset aborts startup delay and clears device address registers.
// [RULE_23] Firmware should disable both timer interrupts before suspend.
// [RULE_24] Global enable bit 0 gates bus reset, bit 1 the 128 us timer.
// [RULE_25] An event on an already pending source does not queue a second request.
// [RULE_26] Of several requests only the lowest vector is taken; others stay pending.
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module prioritized_interrupt_controller
    import irq_ctrl_pkg::*;
(
    input  wire logic            pclk,
    input  wire logic            presetn,
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [7:0]      paddr,
    input  wire logic [31:0]     pwdata,
    output logic      [31:0]     prdata,
    output logic                 pready,
    output logic                 pslverr,
    input  wire irq_src_t        src,
    input  wire cpu_ctl_t        cpu,
    input  wire logic            usb_dp,
    input  wire logic            usb_dm,
    output service_t             service,
    output logic                 global_irq_en,
    output logic                 irq_pending,
    output logic                 usb_bus_reset,
    output logic [PC_W-1:0]      start_pc
);

    logic [7:0]         global_en_r;
    logic [7:0]         ep_en_r;
    logic [NUM_SRC-1:0] pend_r;
    logic               gie_r;
    logic               bus_reset_flag_r;
    logic [11:0]        se0_cnt_r;
    logic               se0_seen_r;
    logic               se0_end_evt_r;
    logic               bus_reset_pulse_r;
    svc_state_t         state_r;
    logic [3:0]         call_cnt_r;
    logic [PC_W-1:0]    vector_r;
    logic               call_active_r;
    logic               irq_pending_r;
    logic [31:0]        prdata_r;
    logic               pready_r;
    logic               pslverr_r;

    logic [NUM_SRC-1:0] enable_map;
    logic [NUM_SRC-1:0] set_vec;
    logic [NUM_SRC-1:0] req_vec;
    logic [NUM_SRC-1:0] grant_vec;
    logic [NUM_SRC-1:0] pend_nxt;
    logic               take;
    logic               wr_acc;
    logic               rd_acc;
    logic               se0;

    // Vector address of pending slot idx: two bytes per entry after the reset entry
    function automatic logic [PC_W-1:0] vec_addr(input logic [NUM_SRC-1:0] onehot);
        logic [PC_W-1:0] a;
        a = RESET_VECTOR;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (onehot[i]) begin
                a = RESET_VECTOR + PC_W'((i + 1) * int'(VECTOR_STEP)); // RULE_18
            end
        end
        return a;
    endfunction : vec_addr

    // Lowest index wins; a fixed chain keeps timing short at 12 sources
    function automatic logic [NUM_SRC-1:0] lowest_first(input logic [NUM_SRC-1:0] r);
        logic [NUM_SRC-1:0] g;
        g = r & (~r + NUM_SRC'(1));
        return g;
    endfunction : lowest_first

    assign se0    = ~usb_dp & ~usb_dm;
    assign wr_acc = psel & penable & ~pready_r & pwrite;
    assign rd_acc = psel & penable & ~pready_r & ~pwrite;

    always_comb begin
        enable_map                = '0;
        enable_map[V_BUS_RESET]   = global_en_r[GE_BUS_RESET];           // RULE_24
        enable_map[V_T128US]      = global_en_r[GE_T128US];              // RULE_24
        enable_map[V_T1024MS]     = global_en_r[GE_T1024MS];             // RULE_01
        enable_map[V_EP_FIRST+:5] = ep_en_r[4:0];                        // RULE_05
        enable_map[V_DAC]         = global_en_r[GE_DAC];                 // RULE_02
        enable_map[V_GPIO]        = global_en_r[GE_GPIO];                // RULE_03
        enable_map[V_I2C]         = global_en_r[GE_I2C];                 // RULE_04
    end

    always_comb begin
        set_vec                = '0;
        set_vec[V_BUS_RESET]   = se0_end_evt_r;                          // RULE_21
        set_vec[V_T128US]      = src.tick_128us;
        set_vec[V_T1024MS]     = src.tick_1024ms;
        set_vec[V_EP_FIRST+:5] = src.ep_event;
        set_vec[V_DAC]         = src.dac_event;
        set_vec[V_GPIO]        = src.gpio_event;
        set_vec[V_I2C]         = src.i2c_event;
    end

    assign req_vec   = pend_r & enable_map;                              // RULE_08
    assign grant_vec = lowest_first(req_vec);                            // RULE_10 RULE_26
    assign take      = cpu.boundary & gie_r & (|req_vec) & (state_r == SVC_IDLE); // RULE_09

    // Event while already pending merges into the same flop; set beats service clear
    assign pend_nxt = (pend_r & ~(take ? grant_vec : '0)) | set_vec;     // RULE_07 RULE_12 RULE_25

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_r <= '0;                                                // RULE_07
        end else begin
            pend_r <= pend_nxt;
        end
    end

    // CPU global interrupt enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gie_r <= 1'b0;
        end else if (take) begin
            gie_r <= 1'b0;                                               // RULE_11
        end else if (cpu.return_from_irq_instr || cpu.enable_irq_instr) begin
            gie_r <= 1'b1;                                               // RULE_14 RULE_15
        end else if (cpu.disable_irq_instr) begin
            gie_r <= 1'b0;                                               // RULE_15
        end
    end

    // Call injection; CPU fetches the vector's jump itself afterwards
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r       <= SVC_IDLE;
            call_cnt_r    <= '0;
            vector_r      <= RESET_VECTOR;
            call_active_r <= 1'b0;
        end else begin
            unique case (state_r)
                SVC_IDLE: begin
                    if (take) begin
                        state_r       <= SVC_CALL;
                        call_cnt_r    <= '0;
                        vector_r      <= vec_addr(grant_vec);            // RULE_13 RULE_18
                        call_active_r <= 1'b1;                           // RULE_13
                    end
                end
                SVC_CALL: begin
                    if (call_cnt_r == CALL_LAST) begin
                        state_r       <= SVC_IDLE;                       // RULE_19
                        call_active_r <= 1'b0;
                    end else begin
                        call_cnt_r    <= call_cnt_r + 4'h1;
                    end
                end
            endcase
        end
    end

    // SE0 timing; detection fixed at the earliest legal point
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            se0_cnt_r         <= '0;
            se0_seen_r        <= 1'b0;
            se0_end_evt_r     <= 1'b0;
            bus_reset_pulse_r <= 1'b0;
        end else begin
            se0_end_evt_r     <= 1'b0;
            bus_reset_pulse_r <= 1'b0;
            if (se0) begin
                if (se0_cnt_r != SE0_DET_CNT) begin
                    se0_cnt_r <= se0_cnt_r + 12'h001;
                end
                if (se0_cnt_r == SE0_DET_CNT - 12'h001) begin
                    se0_seen_r        <= 1'b1;                           // RULE_20
                    bus_reset_pulse_r <= 1'b1;                           // RULE_22
                end
            end else begin
                se0_cnt_r <= '0;
                if (se0_seen_r) begin
                    se0_seen_r    <= 1'b0;
                    se0_end_evt_r <= 1'b1;                               // RULE_21
                end
            end
        end
    end

    // Status bit 5: hardware set wins over a software clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_reset_flag_r <= 1'b0;
        end else if (bus_reset_pulse_r) begin
            bus_reset_flag_r <= 1'b1;                                    // RULE_21
        end else if (wr_acc && paddr == OFF_STATUS && !pwdata[ST_BUS_RESET]) begin
            bus_reset_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_pending_r <= 1'b0;
        end else begin
            irq_pending_r <= |pend_nxt;                                  // RULE_16
        end
    end

    // Enable registers; reserved bits never store
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            global_en_r <= EN_RESET;                                     // RULE_06
            ep_en_r     <= EN_RESET;                                     // RULE_06
        end else if (wr_acc) begin
            if (paddr == OFF_GLOBAL_EN) begin
                global_en_r <= pwdata[7:0] & GE_WR_MASK;                 // RULE_04
            end
            if (paddr == OFF_EP_EN) begin
                ep_en_r <= pwdata[7:0] & EP_WR_MASK;                     // RULE_05
            end
        end
    end

    // APB answer: one wait state, so every access lasts exactly two access cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else begin
            pready_r  <= psel & penable & ~pready_r;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
            if (psel && penable && !pready_r) begin
                unique case (paddr)
                    OFF_GLOBAL_EN: prdata_r <= {24'h00_0000, global_en_r};
                    OFF_EP_EN:     prdata_r <= {24'h00_0000, ep_en_r};
                    OFF_STATUS: begin
                        prdata_r[ST_IRQ_PEND]  <= irq_pending_r;         // RULE_16
                        prdata_r[ST_BUS_RESET] <= bus_reset_flag_r;
                        prdata_r[ST_GIE_SENSE] <= gie_r;                 // RULE_11
                    end
                    OFF_PENDING:   prdata_r <= {20'h0_0000, pend_r};
                    default:       pslverr_r <= 1'b1;
                endcase
            end
        end
    end

    assign prdata              = prdata_r;
    assign pready              = pready_r;
    assign pslverr             = pslverr_r;
    assign service.call_active = call_active_r;
    assign service.vector      = vector_r;
    assign global_irq_en       = gie_r;
    assign irq_pending         = irq_pending_r;
    assign usb_bus_reset       = bus_reset_pulse_r;
    assign start_pc            = vector_r;                               // RULE_17

endmodule : prioritized_interrupt_controller

// file: testbench/irq_ctrl_sva.sv
// Purpose: Port assertions for the interrupt controller
// Assumes: One clock domain, presetn active low
// Notes:   Bound to every controller instance
`timescale 1ns/1ps
module irq_ctrl_sva
    import irq_ctrl_pkg::*;
(
    input wire logic            pclk,
    input wire logic            presetn,
    input wire logic            psel,
    input wire logic            penable,
    input wire logic            pready,
    input wire logic            pslverr,
    input wire cpu_ctl_t        cpu,
    input wire service_t        service,
    input wire logic            global_irq_en,
    input wire logic [PC_W-1:0] start_pc
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_take;
        $rose(service.call_active);
    endsequence
    sequence s_call;
        service.call_active[*8] ##1 service.call_active[*2] ##1 !service.call_active;
    endsequence
    property p_call_len; s_take |-> s_call; endproperty
    property p_take_cause; s_take |-> $past(cpu.boundary) && $past(global_irq_en); endproperty
    property p_take_gie; s_take |-> !global_irq_en; endproperty
    property p_vec; s_take |-> !service.vector[0] && service.vector inside {[14'h0002:14'h0018]}
        && service.vector != 14'h0012; endproperty
    property p_vec_hold; s_take |=> $stable(service.vector)[*8]; endproperty
    property p_start; !$rose(service.call_active) |-> $stable(start_pc); endproperty
    property p_apb_ans; psel && penable && !pready |=> pready; endproperty
    property p_ready_pulse; pready |=> !pready; endproperty
    property p_err; pslverr |-> pready; endproperty
    property p_di; cpu.disable_irq_instr && !cpu.enable_irq_instr && !cpu.return_from_irq_instr
        |=> !global_irq_en; endproperty
    property p_ei; (cpu.enable_irq_instr || cpu.return_from_irq_instr) && !cpu.disable_irq_instr
        |=> global_irq_en || service.call_active; endproperty
    a_call_len: assert property (p_call_len) else $error("call length wrong");
    a_take_cause: assert property (p_take_cause) else $error("call without boundary");
    a_take_gie: assert property (p_take_gie) else $error("enable kept on call");
    a_vec: assert property (p_vec) else $error("bad vector");
    a_vec_hold: assert property (p_vec_hold) else $error("vector moved");
    a_start: assert property (p_start) else $error("start pc differs");
    a_apb_ans: assert property (p_apb_ans) else $error("no pready");
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready too long");
    a_err: assert property (p_err) else $error("pslverr alone");
    a_di: assert property (p_di) else $error("disable ignored");
    a_ei: assert property (p_ei) else $error("enable ignored");
endmodule : irq_ctrl_sva
bind prioritized_interrupt_controller irq_ctrl_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr), .cpu(cpu), .service(service),
    .global_irq_en(global_irq_en), .start_pc(start_pc));

// file: testbench/cpu_model.sv
// Purpose: CPU core stand-in issuing boundaries and handler returns
// Assumes: Four-cycle instructions, short handlers
// Notes:   Enable and disable strobes come from the bench
`timescale 1ns/1ps
module cpu_model
    import irq_ctrl_pkg::*;
(
    input  wire logic     pclk,
    input  wire logic     presetn,
    input  wire service_t service,
    input  wire logic     irq_on_req,
    input  wire logic     irq_off_req,
    output cpu_ctl_t      cpu
);
    logic [1:0] cnt_r;
    logic [3:0] ret_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 2'h0;
            ret_r <= 4'h0;
            cpu   <= '0;
        end else begin
            cnt_r <= cnt_r + 2'h1;
            cpu.boundary <= !service.call_active && cnt_r == 2'h3;
            // Jump plus a short handler before returning
            ret_r <= service.call_active ? 4'hF : ret_r - 4'(ret_r != 4'h0);
            cpu.return_from_irq_instr <= ret_r == 4'h1;
            cpu.enable_irq_instr <= irq_on_req;
            cpu.disable_irq_instr <= irq_off_req;
        end
    end
endmodule : cpu_model

// file: testbench/testbench.sv
// Purpose: Self-checking bench of the interrupt controller
// Assumes: APB answer within a few cycles
// Notes:   Each random round starts from reset
`timescale 1ns/1ps
module testbench
    import irq_ctrl_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, usb_dp, usb_dm;
    logic irq_on_req, irq_off_req, global_irq_en, irq_pending, usb_bus_reset, prev_call;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [PC_W-1:0] start_pc;
    logic [PC_W-1:0] got_q[$];
    irq_src_t src;
    cpu_ctl_t cpu;
    service_t service;
    int num_errors = 0;
    int n_tests = 0;
    int cyc = 0;
    prioritized_interrupt_controller u_prioritized_interrupt_controller (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .src(src), .cpu(cpu), .usb_dp(usb_dp), .usb_dm(usb_dm),
        .service(service), .global_irq_en(global_irq_en), .irq_pending(irq_pending),
        .usb_bus_reset(usb_bus_reset), .start_pc(start_pc));
    cpu_model u_cpu_model (.pclk(pclk), .presetn(presetn), .service(service), .irq_on_req(irq_on_req),
        .irq_off_req(irq_off_req), .cpu(cpu));
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        prev_call <= service.call_active;
        if (service.call_active === 1'b1 && prev_call === 1'b0) got_q.push_back(service.vector);
        cyc++;
        if (cyc == 40000) begin
            num_errors++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("errors %0d checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : finish_test
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] r, output logic e);
        int t;
        t = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && ++t < 20);
        chk("pready", 32'h1, 32'(pready));
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic rd(logic [7:0] a, logic [31:0] mask, logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk("read", exp, r & mask);
    endtask : rd
    // One-cycle enable (on=1) or disable (on=0) instruction strobe
    task automatic pulse(logic on);
        irq_on_req <= on;
        irq_off_req <= !on;
        @(posedge pclk);
        irq_on_req <= 1'b0;
        irq_off_req <= 1'b0;
    endtask : pulse
    task automatic wait_calls(int n);
        for (int t = 0; t < 2000 && got_q.size() < n; t++) @(posedge pclk);
        repeat (40) @(posedge pclk);
    endtask : wait_calls
    task automatic do_reset();
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        got_q.delete();
    endtask : do_reset
    initial begin
        logic [31:0] r;
        logic e;
        logic [11:0] m, en, hit;
        int t;
        void'($urandom(31485));
        {presetn, psel, penable, pwrite, irq_on_req, irq_off_req} = '0;
        {paddr, pwdata, src} = '0;
        {usb_dp, usb_dm} = 2'b10;
        do_reset();
        chk("start pc", 32'h0, 32'(start_pc));
        rd(OFF_GLOBAL_EN, 32'hFFFF_FFFF, 32'h0);
        rd(OFF_EP_EN, 32'hFFFF_FFFF, 32'h0);
        apb(1'b0, 8'h30, 32'h0, r, e);
        chk("unmapped err", 32'h1, 32'(e));
        apb(1'b1, OFF_GLOBAL_EN, 32'hFFFF_FFFF, r, e);
        apb(1'b1, OFF_EP_EN, 32'hFFFF_FFFF, r, e);
        rd(OFF_GLOBAL_EN, 32'hFFFF_FFFF, 32'h77);
        rd(OFF_EP_EN, 32'hFFFF_FFFF, 32'h1F);
        usb_dm <= 1'b0;
        usb_dp <= 1'b0;
        for (t = 0; t < 5000 && usb_bus_reset !== 1'b1; t++) @(posedge pclk);
        chk("se0 window", 32'h1, 32'(t >= 3000 && t <= 4000));
        rd(OFF_PENDING, 32'h1, 32'h0);
        usb_dp <= 1'b1;
        repeat (3) @(posedge pclk);
        rd(OFF_STATUS, 32'hA4, 32'hA0);
        apb(1'b1, OFF_STATUS, 32'h0, r, e);
        rd(OFF_STATUS, 32'h20, 32'h0);
        pulse(1'b1);
        wait_calls(1);
        chk("bus reset vector", 32'h2, 32'(got_q.pop_front()));
        for (int k = 0; k < 8; k++) begin
            do_reset();
            m = (k == 0) ? 12'hEFE : 12'($urandom) & 12'hEFE;
            en = (k == 0) ? 12'hFFF : (k == 1) ? 12'h0 : 12'($urandom);
            hit = m & en;
            pulse(1'b0);
            apb(1'b1, OFF_GLOBAL_EN, {25'h0, en[11:9], 1'b0, en[2:0]}, r, e);
            apb(1'b1, OFF_EP_EN, {27'h0, en[7:3]}, r, e);
            src <= {m[1], m[2], m[7:3], m[9], m[10], m[11]};
            @(posedge pclk);
            src <= {m[1], m[2], m[7:3], m[9], m[10], m[11]};
            @(posedge pclk);
            src <= '0;
            rd(OFF_PENDING, 32'hFFF, 32'(m));
            rd(OFF_STATUS, 32'h84, {24'h0, |m, 7'h0});
            chk("irq pending", 32'(|m), 32'(irq_pending));
            pulse(1'b1);
            wait_calls($countones(hit));
            chk("calls", 32'($countones(hit)), 32'(got_q.size()));
            for (int i = 0; i < 12; i++)
                if (hit[i] && got_q.size() > 0) chk("vector", 32'((i + 1) * 2), 32'(got_q.pop_front()));
            rd(OFF_PENDING, 32'hFFF, 32'(m & ~en));
        end
        // Firmware side: both timers masked before suspend, so ticks stay pending only
        do_reset();
        apb(1'b1, OFF_GLOBAL_EN, 32'h0000_0070, r, e);
        pulse(1'b1);
        src.tick_128us <= 1'b1;
        src.tick_1024ms <= 1'b1;
        @(posedge pclk);
        src <= '0;
        repeat (40) @(posedge pclk);
        chk("timer calls", 32'h0, 32'(got_q.size()));
        chk("gie", 32'h1, 32'(global_irq_en));
        chk("irq pending", 32'h1, 32'(irq_pending));
        rd(OFF_PENDING, 32'hFFF, 32'h6);
        finish_test();
    end
endmodule : testbench
